//--- src/pcr_regs.sv
`timescale 1ns/100ps
// Behaviour
// R1: next pointer, read-only, resets 0x70
// R2: structure version reads 0x1, read-only
// R3: slot bit lockable writable, resets zero
// R4: interrupt message number always reads zero
// R5: max payload lockable writable, resets 2048B
// R6: phantom function support fixed zero
// R7: extended tag support reads one
// R8: L0s acceptable latency fixed zero
// R9: L1 acceptable latency fixed zero
// R10: attention button present, lockable, resets zero
// R11: attention indicator present, lockable, resets zero
// R12: power indicator present, lockable, resets zero
// R13: power limit message captures eight-bit value
// R14: captured fields zero on downstream ports
// R15: two-bit scale captured from same message
// R16: software multiplies value by scale factor
// R17: read-only/reserved writes ignored, reserved reads zero
module pcr_regs
  import pcr_pkg::*;
#(
  parameter logic [3:0] PORT_TYPE = 4'h5
)(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        upstream_i,
  input  wire logic        spl_msg_i,
  input  wire logic [7:0]  spl_value_i,
  input  wire logic [1:0]  spl_scale_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             slot_impl_o,
  output logic      [2:0]  max_payload_o,
  output logic      [7:0]  power_limit_value_o,
  output logic      [1:0]  power_limit_scale_o
);

  // ==========================================================================
  // address phase capture
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_go;
  logic        addr_ok;

  assign addr_ok = hsel_i && hready_i && (htrans_i == PCR_HTRANS_NONSEQ) && (hsize_i == PCR_HSIZE_WORD);
  assign rd_go   = addr_ok && !hwrite_i;

  // writes are committed in the data phase; the slave never stalls
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite_i;
      if (addr_ok)
        wr_addr_q <= haddr_i;
    end
  end

  // ==========================================================================
  // lockable writable state
  logic       lock_q;
  logic       slot_q;
  logic [2:0] mpl_q;
  logic       button_q;
  logic       attn_ind_q;
  logic       pwr_ind_q;
  logic       wr_hdr;
  logic       wr_dcap;

  assign wr_hdr  = wr_pend_q && (wr_addr_q == PCR_CAP_HDR_ADDR) && !lock_q;
  assign wr_dcap = wr_pend_q && (wr_addr_q == PCR_DEV_CAP_ADDR) && !lock_q;

  // lock register: while set, the writable fields freeze; software can clear it again by writing zero
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lock_q <= 1'b0;
    else if (wr_pend_q && (wr_addr_q == PCR_LOCK_ADDR))
      lock_q <= hwdata_i[0];
  end

  // slot implemented bit
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      slot_q <= 1'b0;
    else if (wr_hdr)
      slot_q <= hwdata_i[PCR_SLOT_BIT]; // see R3
  end

  // device capability writable fields; other bits of the word are dropped
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mpl_q      <= PCR_MPL_RST; // see R5
      button_q   <= 1'b0;
      attn_ind_q <= 1'b0;
      pwr_ind_q  <= 1'b0;
    end
    else if (wr_dcap)
    begin
      mpl_q      <= hwdata_i[PCR_MPL_LSB +: 3];    // see R5
      button_q   <= hwdata_i[PCR_BUTTON_BIT];      // see R10
      attn_ind_q <= hwdata_i[PCR_ATTN_IND_BIT];    // see R11
      pwr_ind_q  <= hwdata_i[PCR_PWR_IND_BIT];     // see R12
    end
  end

  // ==========================================================================
  // slot power limit capture
  logic [7:0] splv_q;
  logic [1:0] spls_q;

  // downstream ports never load, so the fields stay zero there
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      splv_q <= 8'h00;
      spls_q <= 2'h0;
    end
    else if (spl_msg_i && upstream_i) // see R14
    begin
      splv_q <= spl_value_i; // see R13
      spls_q <= spl_scale_i; // see R15
    end
  end

  // ==========================================================================
  // read data composition
  logic [31:0] hdr_word;
  logic [31:0] dcap_word;
  logic [31:0] rd_mux;

  always_comb
  begin
    hdr_word                      = 32'h0000_0000; // see R17
    hdr_word[7:0]                 = PCR_CAP_ID;
    hdr_word[PCR_NXT_LSB +: 8]    = PCR_NXT_RST;   // see R1
    hdr_word[PCR_VERSION_LSB +: 4] = PCR_VERSION_RST; // see R2
    hdr_word[PCR_TYPE_LSB +: 4]   = PORT_TYPE;
    hdr_word[PCR_SLOT_BIT]        = slot_q;
    hdr_word[PCR_MSGNUM_LSB +: 5] = 5'h00;         // see R4
  end

  always_comb
  begin
    dcap_word                     = 32'h0000_0000; // see R17
    dcap_word[PCR_MPL_LSB +: 3]   = mpl_q;
    dcap_word[PCR_PHANTOM_LSB +: 2] = 2'h0;        // see R6
    dcap_word[PCR_EXTTAG_BIT]     = 1'b1;          // see R7
    dcap_word[PCR_L0S_LSB +: 3]   = 3'h0;          // see R8
    dcap_word[PCR_L1_LSB +: 3]    = 3'h0;          // see R9
    dcap_word[PCR_BUTTON_BIT]     = button_q;
    dcap_word[PCR_ATTN_IND_BIT]   = attn_ind_q;
    dcap_word[PCR_PWR_IND_BIT]    = pwr_ind_q;
    dcap_word[PCR_SPLV_LSB +: 8]  = splv_q;
    dcap_word[PCR_SPLS_LSB +: 2]  = spls_q;        // factor applied by software, see R16
  end

  // unmapped addresses read zero with an OKAY response
  always_comb
  begin
    if (haddr_i == PCR_CAP_HDR_ADDR)
      rd_mux = hdr_word;
    else if (haddr_i == PCR_DEV_CAP_ADDR)
      rd_mux = dcap_word;
    else if (haddr_i == PCR_LOCK_ADDR)
      rd_mux = {31'h0000_0000, lock_q};
    else if (haddr_i == PCR_SPL_MSG_ADDR)
      rd_mux = {22'h00_0000, spls_q, splv_q};
    else
      rd_mux = 32'h0000_0000;
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hrdata_o <= 32'h0000_0000;
    else if (rd_go)
      hrdata_o <= rd_mux;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hreadyout_o         <= 1'b1;
      hresp_o             <= 1'b0;
      slot_impl_o         <= 1'b0;
      max_payload_o       <= PCR_MPL_RST;
      power_limit_value_o <= 8'h00;
      power_limit_scale_o <= 2'h0;
    end
    else
    begin
      hreadyout_o         <= 1'b1;
      hresp_o             <= 1'b0;
      slot_impl_o         <= slot_q;
      max_payload_o       <= mpl_q;
      power_limit_value_o <= splv_q;
      power_limit_scale_o <= spls_q;
    end
  end

  // ==========================================================================
  // checks
  property p_hdr_const;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_CAP_HDR_ADDR |=> hrdata_o[19:8] == 12'h170 && hrdata_o[31:25] == 7'h00;
  endproperty
  a_hdr_const: assert property (p_hdr_const) else $error("header constant fields wrong"); // see R1

  property p_version;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_CAP_HDR_ADDR |=> hrdata_o[19:16] == 4'h1;
  endproperty
  a_version: assert property (p_version) else $error("version not one"); // see R2

  property p_slot_lock;
    @(posedge clk_i) disable iff (!nrst_i)
    lock_q |=> $stable(slot_q) && $stable(mpl_q);
  endproperty
  a_slot_lock: assert property (p_slot_lock) else $error("locked field changed"); // see R3

  property p_dcap_const;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[11:3] == 9'h004 && hrdata_o[31:28] == 4'h0;
  endproperty
  a_dcap_const: assert property (p_dcap_const) else $error("device cap constants wrong"); // see R6

  property p_mpl_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_dcap |=> mpl_q == $past(hwdata_i[2:0]) ##1 max_payload_o == $past(mpl_q);
  endproperty
  a_mpl_write: assert property (p_mpl_write) else $error("payload write lost"); // see R5

  property p_ind_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_dcap |=> {pwr_ind_q, attn_ind_q, button_q} == $past(hwdata_i[14:12]);
  endproperty
  a_ind_write: assert property (p_ind_write) else $error("indicator write lost"); // see R10

  property p_capture;
    @(posedge clk_i) disable iff (!nrst_i)
    spl_msg_i && upstream_i |=> splv_q == $past(spl_value_i) && spls_q == $past(spl_scale_i) ##1
      power_limit_value_o == $past(splv_q);
  endproperty
  a_capture: assert property (p_capture) else $error("power limit not captured"); // see R13

  property p_downstream;
    @(posedge clk_i) disable iff (!nrst_i)
    !upstream_i && splv_q == 8'h00 && spls_q == 2'h0 |=> splv_q == 8'h00 && spls_q == 2'h0;
  endproperty
  a_downstream: assert property (p_downstream) else $error("downstream capture nonzero"); // see R14

  property p_ro_ignore;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_pend_q && wr_addr_q == PCR_CAP_HDR_ADDR |=> $stable(mpl_q) && $stable(splv_q);
  endproperty
  a_ro_ignore: assert property (p_ro_ignore) else $error("header write touched other state"); // see R17

  property p_msgnum_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_CAP_HDR_ADDR |=> hrdata_o[29:25] == 5'h00;
  endproperty
  a_msgnum_zero: assert property (p_msgnum_zero) else $error("message number not zero"); // see R4

  property p_slot_read;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_CAP_HDR_ADDR |=> hrdata_o[24] == $past(slot_q);
  endproperty
  a_slot_read: assert property (p_slot_read) else $error("slot bit not returned"); // see R3

  property p_slot_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hdr |=> slot_q == $past(hwdata_i[24]);
  endproperty
  a_slot_write: assert property (p_slot_write) else $error("slot write lost"); // see R3

  property p_phantom_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[4:3] == 2'h0;
  endproperty
  a_phantom_zero: assert property (p_phantom_zero) else $error("phantom field not zero"); // see R6

  property p_exttag_one;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[5] == 1'b1;
  endproperty
  a_exttag_one: assert property (p_exttag_one) else $error("extended tag bit not one"); // see R7

  property p_l0s_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[8:6] == 3'h0;
  endproperty
  a_l0s_zero: assert property (p_l0s_zero) else $error("l0s latency not zero"); // see R8

  property p_l1_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[11:9] == 3'h0;
  endproperty
  a_l1_zero: assert property (p_l1_zero) else $error("l1 latency not zero"); // see R9

  property p_ind_lock;
    @(posedge clk_i) disable iff (!nrst_i)
    lock_q |=> $stable(button_q) && $stable(attn_ind_q) && $stable(pwr_ind_q);
  endproperty
  a_ind_lock: assert property (p_ind_lock) else $error("locked presence bit changed"); // see R10

  property p_attn_ind_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_dcap |=> attn_ind_q == $past(hwdata_i[13]);
  endproperty
  a_attn_ind_write: assert property (p_attn_ind_write) else $error("attention indicator write lost"); // see R11

  property p_pwr_ind_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_dcap |=> pwr_ind_q == $past(hwdata_i[14]);
  endproperty
  a_pwr_ind_write: assert property (p_pwr_ind_write) else $error("power indicator write lost"); // see R12

  // the captured fields may move only on a message pulse
  property p_limit_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    !spl_msg_i |=> $stable(splv_q) && $stable(spls_q);
  endproperty
  a_limit_hold: assert property (p_limit_hold) else $error("power limit changed without message"); // see R13

  property p_scale_capture;
    @(posedge clk_i) disable iff (!nrst_i)
    spl_msg_i && upstream_i |=> spls_q == $past(spl_scale_i) ##1 power_limit_scale_o == $past(spls_q);
  endproperty
  a_scale_capture: assert property (p_scale_capture) else $error("power limit scale not captured"); // see R15

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    rd_go && haddr_i == PCR_DEV_CAP_ADDR |=> hrdata_o[17:15] == 3'h0 && hrdata_o[31:28] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero"); // see R17

endmodule : pcr_regs

//--- src/pcr_pkg.sv
package pcr_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [11:0] PCR_CAP_HDR_ADDR  = 12'h040;
  localparam logic [11:0] PCR_DEV_CAP_ADDR  = 12'h044;
  localparam logic [11:0] PCR_LOCK_ADDR     = 12'h0f0;
  localparam logic [11:0] PCR_SPL_MSG_ADDR  = 12'h0f4;

  // ==========================================================================
  // capability header fields
  localparam int          PCR_NXT_LSB       = 8;
  localparam logic [7:0]  PCR_NXT_RST       = 8'h70;
  localparam int          PCR_VERSION_LSB   = 16;
  localparam logic [3:0]  PCR_VERSION_RST   = 4'h1;
  localparam int          PCR_TYPE_LSB      = 20;
  localparam int          PCR_SLOT_BIT      = 24;
  localparam int          PCR_MSGNUM_LSB    = 25;
  localparam logic [7:0]  PCR_CAP_ID        = 8'h10;

  // ==========================================================================
  // device capabilities fields
  localparam int          PCR_MPL_LSB       = 0;
  localparam logic [2:0]  PCR_MPL_RST       = 3'h4;
  localparam int          PCR_PHANTOM_LSB   = 3;
  localparam int          PCR_EXTTAG_BIT    = 5;
  localparam int          PCR_L0S_LSB       = 6;
  localparam int          PCR_L1_LSB        = 9;
  localparam int          PCR_BUTTON_BIT    = 12;
  localparam int          PCR_ATTN_IND_BIT  = 13;
  localparam int          PCR_PWR_IND_BIT   = 14;
  localparam int          PCR_SPLV_LSB      = 18;
  localparam int          PCR_SPLS_LSB      = 26;

  // ==========================================================================
  // bus encodings
  localparam logic [1:0]  PCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  PCR_HSIZE_WORD    = 3'h2;

endpackage : pcr_pkg

//--- testbench/pcr_link_model.sv
`timescale 1ns/100ps
// ==========
// link side: delivers power limit messages
module pcr_link_model (
  input  wire logic       clk_i,
  output logic            spl_msg_o,
  output logic      [7:0] spl_value_o,
  output logic      [1:0] spl_scale_o
);
  // lines idle at zero, then carry the inverse after each message so a late capture shows
  initial
  begin
    spl_msg_o   = 1'b0;
    spl_value_o = 8'h00;
    spl_scale_o = 2'h0;
  end
  // one-cycle pulse with value and scale valid beside it
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(posedge clk_i);
    spl_msg_o   <= 1'b1;
    spl_value_o <= v;
    spl_scale_o <= s;
    @(posedge clk_i);
    spl_msg_o   <= 1'b0;
    spl_value_o <= ~v;
    spl_scale_o <= ~s;
  endtask : send
endmodule : pcr_link_model

//--- testbench/testbench.sv
`timescale 1ns/100ps
// ==========
// bench for the capability registers
module testbench
  import pcr_pkg::*;
;
  logic clk_i, nrst_i, hsel, hwrite, upstream, msg, slot_o, hrdy, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans, sc, scale, ps;
  logic [2:0]  hsize, mpl, ind, mp_o;
  logic [7:0]  val, pv, vv;
  logic [31:0] hwdata, hrdata, rd, x, wd;
  logic        slot;
  int          bad_count, num_checks;
  pcr_regs uut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .upstream_i(upstream),
    .spl_msg_i(msg), .spl_value_i(val), .spl_scale_i(scale), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .slot_impl_o(slot_o), .max_payload_o(mp_o), .power_limit_value_o(pv),
    .power_limit_scale_o(ps));
  pcr_link_model link (.clk_i(clk_i), .spl_msg_o(msg), .spl_value_o(val), .spl_scale_o(scale));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  // expected words built from the field layout
  function automatic logic [31:0] e_hdr();
    return {7'h00, slot, 4'h5, PCR_VERSION_RST, PCR_NXT_RST, PCR_CAP_ID};
  endfunction : e_hdr
  function automatic logic [31:0] e_dcap();
    return {4'h0, sc, vv, 3'h0, ind, 6'h00, 1'b1, 2'h0, mpl};
  endfunction : e_dcap
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // bounded wait for hready at a rising edge
  task automatic wt();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1)
    begin
      bad_count++;
      results();
    end
  endtask : wt
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= PCR_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= PCR_HSIZE_WORD;
    wt();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask : bus
  task automatic rdchk();
    bus(PCR_CAP_HDR_ADDR, 1'b0, 32'h0);
    chk("cap_header", rd, e_hdr());
    bus(PCR_DEV_CAP_ADDR, 1'b0, 32'h0);
    chk("device_capabilities", rd, e_dcap());
    chk("slot_out", {31'h0, slot_o}, {31'h0, slot});
    chk("payload_out", {29'h0, mp_o}, {29'h0, mpl});
    chk("power_out", {22'h0, ps, pv}, {22'h0, sc, vv});
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : rdchk
  // ==========
  // clock at 10 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // main sequence
  initial
  begin
    nrst_i     = 1'b0;
    hsel       = 1'b0;
    haddr      = 12'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    upstream   = 1'b0;
    bad_count  = 0;
    num_checks = 0;
    x          = 32'h032da796;
    slot       = 1'b0;
    mpl        = PCR_MPL_RST;
    ind        = 3'h0;
    vv         = 8'h00;
    sc         = 2'h0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdchk();
    // downstream port ignores the message
    link.send(8'ha5, 2'h3);
    rdchk();
    upstream <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      x = lfsr(x);
      vv = x[7:0];
      sc = i[1:0];
      link.send(vv, sc);
      rdchk();
      bus(PCR_SPL_MSG_ADDR, 1'b0, 32'h0);
      chk("limit_mirror", rd, {22'h0, sc, vv});
    end
    // all ones first, then random words
    for (int i = 0; i < 6; i++)
    begin
      x = lfsr(x);
      wd = (i == 0) ? 32'hffffffff : x;
      bus(PCR_CAP_HDR_ADDR, 1'b1, wd);
      slot = wd[24];
      x = lfsr(x);
      wd = (i == 0) ? 32'hffffffff : x;
      bus(PCR_DEV_CAP_ADDR, 1'b1, wd);
      mpl = wd[2:0];
      ind = wd[14:12];
      rdchk();
    end
    // locked fields stay frozen
    bus(PCR_LOCK_ADDR, 1'b1, 32'h1);
    bus(PCR_LOCK_ADDR, 1'b0, 32'h0);
    chk("lock_set", rd, 32'h1);
    bus(PCR_CAP_HDR_ADDR, 1'b1, ~e_hdr());
    bus(PCR_DEV_CAP_ADDR, 1'b1, ~e_dcap());
    rdchk();
    // a reset in mid-run drops the lock and brings every default back
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    slot = 1'b0;
    mpl  = PCR_MPL_RST;
    ind  = 3'h0;
    vv   = 8'h00;
    sc   = 2'h0;
    rdchk();
    bus(PCR_LOCK_ADDR, 1'b0, 32'h0);
    chk("lock_after_reset", rd, 32'h0);
    bus(PCR_LOCK_ADDR, 1'b1, 32'h0);
    bus(12'h0f8, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    results();
  end
endmodule : testbench
